// File: logic/ssr_pkg.sv
package ssr_pkg;
    // ------------------------------------------------------------
    // Commands and address layout
    // ------------------------------------------------------------
    localparam logic [7:0] SSR_CMD_FAST_READ = 8'h0b;
    localparam logic [7:0] SSR_CMD_WRITE = 8'h02;
    localparam int SSR_ADDR_W = 14;
    localparam int SSR_DIR_MSB = 15;
    localparam int SSR_DIR_LSB = 14;
    localparam logic [1:0] SSR_DIR_INC = 2'h0;
    localparam logic [1:0] SSR_DIR_RSVD = 2'h1;
    localparam logic [1:0] SSR_DIR_DEC = 2'h2;
    localparam logic [1:0] SSR_DIR_STATIC = 2'h3;
    localparam logic [2:0] SSR_BIT_LAST = 3'h7;
    localparam logic [1:0] SSR_ADDR_BYTES = 2'h2;
    localparam logic [7:0] SSR_BYTE_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Protocol states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        SSR_OFF = 7'h01,
        SSR_WAIT_HIGH = 7'h02,
        SSR_IDLE = 7'h04,
        SSR_CMD = 7'h08,
        SSR_ADDR = 7'h10,
        SSR_DUMMY = 7'h20,
        SSR_DATA = 7'h40
    } ssr_state_t;

    typedef struct packed {
        logic [2:0] clk;
        logic [2:0] sel;
        logic [2:0] din;
    } ssr_sync_t;

    typedef struct packed {
        logic req;
        logic wr;
        logic [SSR_ADDR_W-1:0] addr;
        logic [7:0] data;
    } ssr_reg_req_t;

    typedef struct packed {
        ssr_sync_t sync;
        ssr_state_t state;
        logic isRead;
        logic [7:0] shiftIn;
        logic [2:0] bitCnt;
        logic [1:0] addrCnt;
        logic [1:0] dir;
        logic [SSR_ADDR_W-1:0] addr;
        logic [7:0] shiftOut;
        logic outEn;
        logic holdLow;
        logic awake;
        ssr_reg_req_t req;
        logic rdDone;
        logic rdAbort;
        logic wrAbort;
    } ssr_all_t;
endpackage

// File: logic/ssr_spi_slave.sv
// Contract
// - Pins ignored entirely until initialization done.
// - After initialization, wait for select_n rising edge before acting.
// - Init during low select_n: no register effect until select_n high.
// - Uninitialized: serial_out undriven, reads all ones via pull-up.
// - Not fully on: no internal effect; select_n fall requests wake.
// - Wake request is local to this device only.
// - Until awake, drive serial_out low while select_n low.
// - Woken mid-frame: ignore clock and data, hold low until select_n high.
// - After traffic, stay communicating until master permits lower state.
// - Read: 0Bh, two address bytes, one dummy byte.
// - Read data MSB first, launched on falling edges after last dummy.
// - select_n high releases serial_out.
// - Direction 00 increment, 10 decrement, 11 static for reads and writes.
// - Near end of each read byte, step address and capture next byte.
// - Write: 02h, two address bytes, data MSB first on rising edges.
// - Write commits only when full register received; partial discarded.
// - Each register read latches its value at read start.
// - Read side effect only after access begins; master sees old value.
// - Multi-byte side effect may wait for all bytes; each read triggers.
// - Events between capture and clear held pending, applied afterwards.
// - Modes 0 and 3; sample rising edges, launch falling edges.
// - Direction 01 decodes as increment.
// - Address MSB byte first; low 14 bits address, top two direction.
module ssr_spi_slave
    import ssr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic initDone,
    input wire logic fullyOn,
    input wire logic serial_clock,
    input wire logic select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serialOutEn,
    output logic wakeReq,
    output logic stayAwake,
    input wire logic lowPowerAllowed,
    output logic regReq,
    output logic regWr,
    output logic [SSR_ADDR_W-1:0] regAddr,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    output logic regRdDone,
    output logic regRdAbort,
    output logic regWrAbort
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ssr_all_t s;
    ssr_all_t next_s;
    logic clkRise;
    logic clkFall;
    logic selRise;
    logic selFall;
    logic selLow;
    logic dinBit;
    logic [7:0] byteIn;
    logic [SSR_ADDR_W-1:0] stepAddr;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The byte slicing below hard-wires six address bits in the first address byte
    if (SSR_ADDR_W != 14 || SSR_DIR_MSB != 15 || SSR_DIR_LSB != 14) begin : g_bad_layout
        $error("address layout must be 14 address bits under a 2-bit direction");
    end

    // Bit 0 of each sync chain feeds only bit 1.
    assign clkRise = s.sync.clk[1] & ~s.sync.clk[2];
    assign clkFall = ~s.sync.clk[1] & s.sync.clk[2];
    assign selRise = s.sync.sel[1] & ~s.sync.sel[2];
    assign selFall = ~s.sync.sel[1] & s.sync.sel[2];
    assign selLow = ~s.sync.sel[2];
    assign dinBit = s.sync.din[2];
    assign byteIn = {s.shiftIn[6:0], dinBit};

    always_comb begin
        unique case (s.dir)
            SSR_DIR_INC, SSR_DIR_RSVD: stepAddr = s.addr + 1'b1;
            SSR_DIR_DEC: stepAddr = s.addr - 1'b1;
            SSR_DIR_STATIC: stepAddr = s.addr;
        endcase
    end

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        // Three flops per pin; the link clock is only sampled here
        next_s.sync.clk = {s.sync.clk[1:0], serial_clock};
        next_s.sync.sel = {s.sync.sel[1:0], select_n};
        next_s.sync.din = {s.sync.din[1:0], serial_in};
        next_s.req.req = 1'b0;
        next_s.rdDone = 1'b0;
        next_s.rdAbort = 1'b0;
        next_s.wrAbort = 1'b0;
        if (!fullyOn) begin
            next_s.awake = 1'b0;
        end else if (lowPowerAllowed && !selLow) begin
            next_s.awake = 1'b0;
        end
        if (!initDone) begin
            next_s.state = SSR_OFF;
            next_s.outEn = 1'b0;
            next_s.holdLow = 1'b0;
        end else begin
            unique case (s.state)
                SSR_OFF: begin
                    next_s.state = SSR_WAIT_HIGH;
                end
                SSR_WAIT_HIGH: begin
                    if (selRise) begin
                        next_s.state = SSR_IDLE;
                    end
                end
                SSR_IDLE: begin
                    if (selFall) begin
                        next_s.bitCnt = 3'h0;
                        next_s.addrCnt = 2'h0;
                        if (fullyOn) begin
                            next_s.state = SSR_CMD;
                            next_s.awake = 1'b1;
                        end else begin
                            next_s.holdLow = 1'b1;
                            next_s.outEn = 1'b1;
                            next_s.shiftOut = SSR_BYTE_ZERO;
                        end
                    end
                end
                SSR_CMD, SSR_ADDR, SSR_DUMMY, SSR_DATA: begin
                    if (clkRise) begin
                        next_s.shiftIn = byteIn;
                        next_s.bitCnt = s.bitCnt + 1'b1;
                    end
                    if (clkRise && s.bitCnt == SSR_BIT_LAST) begin
                        unique case (s.state)
                            SSR_CMD: begin
                                if (byteIn == SSR_CMD_FAST_READ) begin
                                    next_s.isRead = 1'b1;
                                    next_s.state = SSR_ADDR;
                                end else if (byteIn == SSR_CMD_WRITE) begin
                                    next_s.isRead = 1'b0;
                                    next_s.state = SSR_ADDR;
                                end else begin
                                    next_s.state = SSR_WAIT_HIGH;
                                end
                            end
                            SSR_ADDR: begin
                                next_s.addrCnt = s.addrCnt + 1'b1;
                                if (s.addrCnt == 2'h0) begin
                                    next_s.dir = byteIn[7:6];
                                    next_s.addr[SSR_ADDR_W-1:8] = byteIn[5:0];
                                end else begin
                                    next_s.addr[7:0] = byteIn;
                                    next_s.state = s.isRead ? SSR_DUMMY : SSR_DATA;
                                    if (s.isRead) begin
                                        next_s.req.req = 1'b1;
                                        next_s.req.wr = 1'b0;
                                        next_s.req.addr = {s.addr[SSR_ADDR_W-1:8], byteIn};
                                    end
                                end
                            end
                            SSR_DUMMY: begin
                                next_s.state = SSR_DATA;
                                next_s.shiftOut = regRdData;
                            end
                            default: begin
                                if (!s.isRead) begin
                                    // Register commits only on a whole byte
                                    next_s.req.req = 1'b1;
                                    next_s.req.wr = 1'b1;
                                    next_s.req.addr = s.addr;
                                    next_s.req.data = byteIn;
                                    next_s.addr = stepAddr;
                                end else begin
                                    next_s.rdDone = 1'b1;
                                end
                            end
                        endcase
                    end
                    // Read the next byte one rising edge before it is needed
                    if (clkRise && s.state == SSR_DATA && s.isRead &&
                        s.bitCnt == 3'h6) begin
                        next_s.addr = stepAddr;
                        next_s.req.req = 1'b1;
                        next_s.req.wr = 1'b0;
                        next_s.req.addr = stepAddr;
                    end
                    if (clkRise && s.state == SSR_DATA && s.isRead &&
                        s.bitCnt == SSR_BIT_LAST) begin
                        next_s.shiftOut = regRdData;
                    end
                    if (clkFall && s.state == SSR_DATA && s.isRead) begin
                        // First fall after the last dummy bit shows the MSB
                        next_s.outEn = 1'b1;
                        if (s.outEn && s.bitCnt != 3'h0) begin
                            next_s.shiftOut = {s.shiftOut[6:0], 1'b0};
                        end
                    end
                    if (selRise) begin
                        next_s.state = SSR_IDLE;
                        next_s.outEn = 1'b0;
                        // Only a cut data byte is a lost write; a cut header is not
                        next_s.wrAbort = ~s.isRead & (s.state == SSR_DATA) &
                            (s.bitCnt != 3'h0);
                        next_s.rdAbort = s.isRead & (s.state == SSR_DATA) &
                            (s.bitCnt != 3'h0);
                    end
                end
                default: begin
                    next_s.state = SSR_WAIT_HIGH;
                end
            endcase
            // Wake mid-frame: keep holding low until the frame ends
            if (s.holdLow && selRise) begin
                next_s.holdLow = 1'b0;
                next_s.outEn = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '{sync: '{clk: 3'h0, sel: 3'h7, din: 3'h0},
                   state: SSR_OFF, isRead: 1'b0, shiftIn: 8'h00,
                   bitCnt: 3'h0, addrCnt: 2'h0, dir: 2'h0,
                   addr: '0, shiftOut: 8'h00, outEn: 1'b0,
                   holdLow: 1'b0, awake: 1'b0,
                   req: '{req: 1'b0, wr: 1'b0, addr: '0, data: 8'h00},
                   rdDone: 1'b0, rdAbort: 1'b0, wrAbort: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Holding low loads a zero byte, so the flop alone already shows low
    assign serial_out = s.shiftOut[7];
    assign serialOutEn = s.outEn & initDone;
    // Wake is asserted only toward this device's power logic
    assign wakeReq = s.holdLow;
    assign stayAwake = s.awake;
    assign regReq = s.req.req;
    assign regWr = s.req.wr;
    assign regAddr = s.req.addr;
    assign regWrData = s.req.data;
    assign regRdDone = s.rdDone;
    assign regRdAbort = s.rdAbort;
    assign regWrAbort = s.wrAbort;
endmodule

// File: sim/ssr_spi_slave_asserts.sv
module ssr_spi_slave_asserts (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic initDone,
    input wire logic fullyOn,
    input wire logic select_n,
    input wire logic serial_out,
    input wire logic serialOutEn,
    input wire logic wakeReq,
    input wire logic stayAwake,
    input wire logic lowPowerAllowed,
    input wire logic regReq,
    input wire logic regRdAbort,
    input wire logic regWrAbort
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // Port checks
    // --------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Pins pass a 3-flop sync, so reactions get a short window
    sequence s_sleep_fall; $fell(select_n) && !fullyOn && initDone; endsequence
    sequence s_sel_rise; $rose(select_n); endsequence
    property p_no_init; !initDone |-> !serialOutEn && !regReq; endproperty
    a_no_init: assert property (p_no_init) else $error("pins acted before init");
    property p_quiet; !fullyOn && !$past(fullyOn) |-> !regReq; endproperty
    a_quiet: assert property (p_quiet) else $error("request in low power");
    property p_hold_low; serialOutEn && !fullyOn |-> !serial_out; endproperty
    a_hold_low: assert property (p_hold_low) else $error("output not low");
    property p_wake; s_sleep_fall |-> ##[1:8] wakeReq; endproperty
    a_wake: assert property (p_wake) else $error("no wake request");
    property p_release; s_sel_rise |-> ##[1:8] !serialOutEn; endproperty
    a_release: assert property (p_release) else $error("output not released");
    property p_stay; stayAwake && fullyOn && !lowPowerAllowed |=> stayAwake; endproperty
    a_stay: assert property (p_stay) else $error("left awake state");
    property p_abort; regRdAbort || regWrAbort |-> select_n; endproperty
    a_abort: assert property (p_abort) else $error("abort inside frame");
    property p_one_req; regReq |=> !regReq; endproperty
    a_one_req: assert property (p_one_req) else $error("request too long");
    // A wake that ends inside a frame must keep the line driven low
    property p_wake_low; wakeReq |-> serialOutEn && !serial_out; endproperty
    a_wake_low: assert property (p_wake_low) else $error("wake not low");
endmodule

bind ssr_spi_slave ssr_spi_slave_asserts i_ssr_spi_slave_asserts (.*);

// File: sim/ssr_host.sv
module ssr_host (
    input wire logic core_clk,
    input wire logic serial_out,
    input wire logic serialOutEn,
    output logic serial_clock = 1'b0,
    output logic select_n = 1'b1,
    output logic serial_in = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic idleLvl = 1'b0;
    logic pinLvl;
    // --------
    // Serial master
    // --------
    // Weak pull-up: a floating line reads as ones
    assign pinLvl = serialOutEn ? serial_out : 1'b1;
    task automatic half();
        repeat (4) @(posedge core_clk);
    endtask
    task automatic frame_start(input logic mode);
        idleLvl = mode;
        serial_clock <= mode;
        half();
        select_n <= 1'b0;
        half();
    endtask
    // Sample at our rising edge; later, the slave may already reload its next byte
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            serial_clock <= 1'b0;
            serial_in <= tx[7 - i];
            half();
            rx = {rx[6:0], pinLvl};
            serial_clock <= 1'b1;
            half();
        end
    endtask
    task automatic frame_end();
        serial_clock <= idleLvl;
        half();
        select_n <= 1'b1;
        serial_in <= ~serial_in;
        half();
        half();
    endtask
endmodule

// File: sim/ssr_spi_slave_tb_top.sv
module ssr_spi_slave_tb_top
    import ssr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, initDone, fullyOn, lowPowerAllowed, serial_clock, select_n, serial_in;
    logic serial_out, serialOutEn, wakeReq, stayAwake, regReq, regWr, regRdDone, regRdAbort;
    logic regWrAbort;
    logic sawWake = 1'b0;
    logic [SSR_ADDR_W-1:0] regAddr;
    logic [7:0] regWrData, regRdData;
    logic [21:0] expW[$];
    int n_errors = 0, n_compared = 0, nReq = 0, nDone = 0, nRdAb = 0, nWrAb = 0, mark;
    integer seed = 32'h3278;
    ssr_spi_slave i_ssr_spi_slave (.*);
    ssr_host i_ssr_host (.*);
    // --------
    // Register file stand-in and monitors
    // --------
    function automatic logic [7:0] rd_val(input logic [13:0] ad);
        return ad[7:0] ^ {2'h0, ad[13:8]} ^ 8'h5a;
    endfunction
    always_comb regRdData = rd_val(regAddr);
    task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    always @(posedge core_clk) begin
        nReq += (regReq === 1'b1);
        nDone += (regRdDone === 1'b1);
        nRdAb += (regRdAbort === 1'b1);
        nWrAb += (regWrAbort === 1'b1);
        sawWake |= (wakeReq === 1'b1);
        if (regReq === 1'b1 && regWr === 1'b1)
            chk({regAddr, regWrData}, expW.size() > 0 ? expW.pop_front() : 22'h3fffff);
    end
    task automatic end_sim();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Kind 1: line floats, kind 2: held low; wakeAt marks the data byte where power returns
    task automatic frame(logic [7:0] cmd, logic [15:0] a, int n, int p, int kind, int wakeAt);
        logic [7:0] rx;
        logic [7:0] tx;
        logic [13:0] ad;
        logic isRd;
        ad = a[13:0];
        tx = $random(seed);
        isRd = (cmd == SSR_CMD_FAST_READ);
        i_ssr_host.frame_start(seed[0]);
        i_ssr_host.xfer(cmd, 8, rx);
        i_ssr_host.xfer(a[15:8], 8, rx);
        i_ssr_host.xfer(a[7:0], 8, rx);
        if (isRd) i_ssr_host.xfer(tx, 8, rx);
        for (int k = 0; k < n; k++) begin
            if (k == wakeAt) {initDone, fullyOn} <= 2'h3;
            tx = $random(seed);
            // Queue before sending: the request lands while the byte's last bit ends
            if (!isRd && kind == 0) expW.push_back({ad, tx});
            i_ssr_host.xfer(tx, 8, rx);
            if (isRd) chk(rx, kind == 1 ? 8'hff : kind == 2 ? 8'h00 : rd_val(ad));
            ad = a[15:14] == SSR_DIR_DEC ? ad - 14'h1 :
                 a[15:14] == SSR_DIR_STATIC ? ad : ad + 14'h1;
        end
        i_ssr_host.xfer(tx, p, rx);
        i_ssr_host.frame_end();
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (50000) @(posedge core_clk);
        n_errors++;
        end_sim();
    end
    initial begin
        // Permission to drop power starts withheld, so traffic keeps the device awake
        {rst, initDone, fullyOn, lowPowerAllowed} = 4'h8;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        frame(SSR_CMD_FAST_READ, 16'h0010, 1, 0, 1, -1);
        frame(SSR_CMD_WRITE, 16'h0020, 2, 0, 1, 1);
        chk(nReq, 0);
        frame(SSR_CMD_FAST_READ, 16'h0000, 1, 0, 0, -1);
        mark = nReq;
        // An unknown command must leave the rest of its frame without effect
        frame(8'h9f, 16'h0010, 1, 0, 3, -1);
        chk(nReq - mark, 0);
        mark = nDone;
        for (int d = 0; d < 4; d++)
            frame(SSR_CMD_FAST_READ, {d[1:0], 14'($random(seed))}, 3, 0, 0, -1);
        chk(nDone - mark, 12);
        for (int d = 0; d < 4; d++)
            frame(SSR_CMD_WRITE, {d[1:0], 14'($random(seed))}, 2, 0, 0, -1);
        mark = nWrAb;
        frame(SSR_CMD_WRITE, 16'h0123, 1, 4, 0, -1);
        chk(nWrAb - mark, 1);
        mark = nRdAb;
        frame(SSR_CMD_FAST_READ, 16'h8123, 1, 3, 0, -1);
        chk(nRdAb - mark, 1);
        chk(stayAwake, 1'b1);
        lowPowerAllowed <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk(stayAwake, 1'b0);
        {lowPowerAllowed, fullyOn} <= 2'h0;
        mark = nReq;
        frame(SSR_CMD_FAST_READ, 16'h0040, 2, 0, 2, -1);
        frame(SSR_CMD_FAST_READ, 16'h0040, 2, 0, 2, 0);
        chk(nReq - mark, 0);
        chk(sawWake, 1'b1);
        frame(SSR_CMD_FAST_READ, 16'hc040, 2, 0, 0, -1);
        chk(expW.size(), 0);
        end_sim();
    end
endmodule
